// File: src/ira_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef IRA_REGS_VH
`define IRA_REGS_VH

`define IRA_ADDR_W 8
`define IRA_DATA_W 8
`define IRA_WORD_W 16
`define IRA_IADDR_W 8

`define IRA_OFS_IRQ_STATUS 8'h14
`define IRA_OFS_IRQ_ENABLE 8'h17
`define IRA_OFS_HOLD_LO 8'h1c
`define IRA_OFS_HOLD_HI 8'h1d
`define IRA_OFS_IADDR 8'h1e
`define IRA_OFS_PENDING 8'h1f
`define IRA_OFS_ENHANCE 8'h6c

`define IRA_BIT_DONE 0
`define IRA_BIT_PENDING 0
`define IRA_BIT_HYST 0
`define IRA_BIT_SQUELCH 1
`define IRA_BIT_VLC 2
`define IRA_BIT_SPEEDUP 5
`define IRA_ENHANCE_RW_MASK 8'he7
`define IRA_ENHANCE_RESET 8'h00

`define IRA_LOC_UPPER_THR 8'h0f
`define IRA_LOC_LOWER_THR 8'h42

`define IRA_CLK_MHZ 250
`define IRA_SLOT_PERIOD_NS 62500
`define IRA_SLOT_CYCLES (`IRA_SLOT_PERIOD_NS * `IRA_CLK_MHZ / 1000)

`endif

// File: src/ira_slot_timer.v
// Free-running divider giving one-cycle indirect update slot pulses
`timescale 1ns/100ps
module ira_slot_timer #(
	parameter CYCLES = 15625
) (
	input wire core_clk,
	input wire nrst,
	output reg slot
);

	localparam [31:0] LAST_COUNT = CYCLES - 1;

	reg [15:0] count;

	always @(posedge core_clk) begin
		if (!nrst) begin
			count <= 16'h0000;
			slot <= 1'b0;
		end else if (count == LAST_COUNT[15:0]) begin
			count <= 16'h0000;
			slot <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			slot <= 1'b0;
		end
	end

endmodule

// File: src/ira_top.v
// Indirect register access engine with enhancement-enable selects
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "ira_regs.vh"

module ira_top #(
	parameter SLOT_CYCLES = `IRA_SLOT_CYCLES
) (
	input wire core_clk,
	input wire nrst,
	input wire [`IRA_ADDR_W-1:0] reg_addr,
	input wire [`IRA_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`IRA_DATA_W-1:0] reg_rdata,
	input wire [`IRA_WORD_W-1:0] loop_current_meas,
	input wire [`IRA_WORD_W-1:0] loop_voltage_meas,
	output wire converter_speedup_sel,
	output wire voltage_loop_closure_sel,
	output wire converter_audio_squelch_en,
	output wire loop_closure_hyst_en,
	output reg loop_closed,
	output wire indirect_access_pending,
	output wire indirect_done_irq
);

	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT_SLOT = 2'b01;

	reg [1:0] state;
	reg [`IRA_WORD_W-1:0] indirect_data_holding;
	reg [`IRA_IADDR_W-1:0] indirect_address_reg;
	reg data_written;
	reg op_is_write;
	reg [`IRA_DATA_W-1:0] enhance;
	reg done_status;
	reg done_enable;
	reg [`IRA_WORD_W-1:0] loop_closure_upper_threshold;
	reg [`IRA_WORD_W-1:0] loop_closure_lower_threshold;
	reg [`IRA_DATA_W-1:0] next_rdata;
	reg next_closed;
	wire slot;
	wire [`IRA_WORD_W-1:0] closure_meas;

	// Decoded strobes and threshold comparator outputs
	wire wr_hold_lo;
	wire wr_hold_hi;
	wire wr_iaddr;
	wire service;
	wire service_write;
	wire service_read;
	wire wr_enhance;
	wire wr_irq_enable;
	wire clr_done;
	wire above_upper;
	wire below_lower;

	// Sequencer next values
	reg [1:0] next_state;
	reg [`IRA_WORD_W-1:0] next_holding;
	reg [`IRA_IADDR_W-1:0] next_iaddr;
	reg next_data_written;
	reg next_op_is_write;

	// Direct register and threshold next values
	reg [`IRA_DATA_W-1:0] next_enhance;
	reg next_done_status;
	reg next_done_enable;
	reg [`IRA_WORD_W-1:0] next_upper;
	reg [`IRA_WORD_W-1:0] next_lower;

	// Direct address decode
	wire hit_hold_lo;
	wire hit_hold_hi;
	wire hit_iaddr;
	wire hit_irq_status;
	wire hit_irq_enable;
	wire hit_enhance;

	// Kept out of reset on purpose: contents are undefined until written
	reg [`IRA_WORD_W-1:0] indirect_mem [0:(1<<`IRA_IADDR_W)-1];

	// One-cycle slot pulse every SLOT_CYCLES clocks, 16 kHz at the default rate
	ira_slot_timer #(
		.CYCLES(SLOT_CYCLES)
	) i_ira_slot_timer (
		.core_clk(core_clk),
		.nrst(nrst),
		.slot(slot)
	);

	assign hit_hold_lo = reg_addr == `IRA_OFS_HOLD_LO;
	assign hit_hold_hi = reg_addr == `IRA_OFS_HOLD_HI;
	assign hit_iaddr = reg_addr == `IRA_OFS_IADDR;
	assign hit_irq_status = reg_addr == `IRA_OFS_IRQ_STATUS;
	assign hit_irq_enable = reg_addr == `IRA_OFS_IRQ_ENABLE;
	assign hit_enhance = reg_addr == `IRA_OFS_ENHANCE;

	// Holding and address writes during a pending transfer are dropped so the queued one stays intact
	assign wr_hold_lo = reg_wr && hit_hold_lo && state == ST_IDLE;
	assign wr_hold_hi = reg_wr && hit_hold_hi && state == ST_IDLE;
	assign wr_iaddr = reg_wr && hit_iaddr && state == ST_IDLE;
	assign wr_enhance = reg_wr && hit_enhance;
	assign wr_irq_enable = reg_wr && hit_irq_enable;
	assign clr_done = reg_wr && hit_irq_status && reg_wdata[`IRA_BIT_DONE];

	assign service = state == ST_WAIT_SLOT && slot;
	assign service_write = service && op_is_write;
	assign service_read = service && !op_is_write;

	// Pending is the wait state itself, so it cannot disagree with the sequencer
	assign indirect_access_pending = state == ST_WAIT_SLOT;
	assign indirect_done_irq = done_status & done_enable;

	// Select outputs come straight from the stored register bits
	assign converter_speedup_sel = enhance[`IRA_BIT_SPEEDUP];
	assign voltage_loop_closure_sel = enhance[`IRA_BIT_VLC];
	assign converter_audio_squelch_en = enhance[`IRA_BIT_SQUELCH];
	assign loop_closure_hyst_en = enhance[`IRA_BIT_HYST];

	// Next-state logic of the transfer sequencer
	always @* begin
		next_state = state;
		next_holding = indirect_data_holding;
		next_iaddr = indirect_address_reg;
		next_data_written = data_written;
		next_op_is_write = op_is_write;
		case (state)
			ST_IDLE: begin
				if (wr_hold_lo) begin
					next_holding[7:0] = reg_wdata;
					next_data_written = 1'b1;
				end
				if (wr_hold_hi) begin
					next_holding[15:8] = reg_wdata;
					next_data_written = 1'b1;
				end
				if (wr_iaddr) begin
					next_iaddr = reg_wdata;
					// Direction latched here; the holding flag restarts per request
					next_op_is_write = data_written;
					next_data_written = 1'b0;
					next_state = ST_WAIT_SLOT;
				end
			end
			ST_WAIT_SLOT: begin
				if (service) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Transfer sequencer registers; the array is read only here, on a clock edge
	always @(posedge core_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			data_written <= 1'b0;
			op_is_write <= 1'b0;
			indirect_address_reg <= {`IRA_IADDR_W{1'b0}};
			indirect_data_holding <= {`IRA_WORD_W{1'b0}};
		end else begin
			state <= next_state;
			data_written <= next_data_written;
			op_is_write <= next_op_is_write;
			indirect_address_reg <= next_iaddr;
			// Host byte writes are refused while pending, so service never collides
			if (service_read) begin
				indirect_data_holding <= indirect_mem[indirect_address_reg];
			end else begin
				indirect_data_holding <= next_holding;
			end
		end
	end

	// Memory write port, only reached through the holding register
	always @(posedge core_clk) begin
		if (service_write) begin
			indirect_mem[indirect_address_reg] <= indirect_data_holding;
		end
	end

	// Shadow copies of the two threshold words, so the comparator needs no read port
	always @* begin
		next_upper = loop_closure_upper_threshold;
		next_lower = loop_closure_lower_threshold;
		if (service_write && indirect_address_reg == `IRA_LOC_UPPER_THR) begin
			next_upper = indirect_data_holding;
		end
		if (service_write && indirect_address_reg == `IRA_LOC_LOWER_THR) begin
			next_lower = indirect_data_holding;
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			loop_closure_upper_threshold <= {`IRA_WORD_W{1'b0}};
			loop_closure_lower_threshold <= {`IRA_WORD_W{1'b0}};
		end else begin
			loop_closure_upper_threshold <= next_upper;
			loop_closure_lower_threshold <= next_lower;
		end
	end

	// Next values of the direct control and status registers
	always @* begin
		next_enhance = enhance;
		next_done_enable = done_enable;
		next_done_status = done_status;
		if (wr_enhance) begin
			// Bits 3 and 4 are never stored, so they read back zero; bits 6 and 7 are kept
			next_enhance = reg_wdata & `IRA_ENHANCE_RW_MASK;
		end
		if (wr_irq_enable) begin
			next_done_enable = reg_wdata[`IRA_BIT_DONE];
		end
		// Set wins over a write-one clear in the same cycle
		if (service) begin
			next_done_status = 1'b1;
		end else if (clr_done) begin
			next_done_status = 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			enhance <= `IRA_ENHANCE_RESET;
			done_status <= 1'b0;
			done_enable <= 1'b0;
		end else begin
			enhance <= next_enhance;
			done_status <= next_done_status;
			done_enable <= next_done_enable;
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		next_rdata = {`IRA_DATA_W{1'b0}};
		case (reg_addr)
			`IRA_OFS_HOLD_LO: next_rdata = indirect_data_holding[7:0];
			`IRA_OFS_HOLD_HI: next_rdata = indirect_data_holding[15:8];
			`IRA_OFS_IADDR: next_rdata = indirect_address_reg;
			`IRA_OFS_PENDING: next_rdata[`IRA_BIT_PENDING] = indirect_access_pending;
			`IRA_OFS_IRQ_STATUS: next_rdata[`IRA_BIT_DONE] = done_status;
			`IRA_OFS_IRQ_ENABLE: next_rdata[`IRA_BIT_DONE] = done_enable;
			`IRA_OFS_ENHANCE: next_rdata = enhance;
			default: next_rdata = {`IRA_DATA_W{1'b0}};
		endcase
	end

	// Read data stands for one cycle only, then returns to zero
	always @(posedge core_clk) begin
		if (!nrst) begin
			reg_rdata <= {`IRA_DATA_W{1'b0}};
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= {`IRA_DATA_W{1'b0}};
		end
	end

	// Loop-closure decision
	assign closure_meas = voltage_loop_closure_sel ? loop_voltage_meas : loop_current_meas;
	assign above_upper = closure_meas > loop_closure_upper_threshold;
	assign below_lower = closure_meas < loop_closure_lower_threshold;

	// Hysteresis only widens the window once the loop is already closed
	always @* begin
		next_closed = above_upper;
		if (loop_closure_hyst_en && loop_closed) begin
			next_closed = !below_lower;
		end
	end

	// Registered so the decision does not follow input glitches within a cycle
	always @(posedge core_clk) begin
		if (!nrst) begin
			loop_closed <= 1'b0;
		end else begin
			loop_closed <= next_closed;
		end
	end

endmodule

// File: bench/ira_sva.sv
// Port assertions for the indirect access engine
`timescale 1ns/100ps
module ira_sva #(
	parameter int SLOT_CYCLES = 32
) (
	input wire core_clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire converter_speedup_sel,
	input wire voltage_loop_closure_sel,
	input wire converter_audio_squelch_en,
	input wire loop_closure_hyst_en,
	input wire indirect_access_pending
);
	localparam int SLOT_MAX = SLOT_CYCLES + 1;
	wire [3:0] sel = {converter_speedup_sel, voltage_loop_closure_sel,
		converter_audio_squelch_en, loop_closure_hyst_en};
	wire pend = indirect_access_pending;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_enh_wr;
		reg_wr && reg_addr == 8'h6c;
	endsequence
	sequence s_req;
		reg_wr && reg_addr == 8'h1e && !pend;
	endsequence
	AST_INDIRECT_HIDDEN: assert property (reg_rd && (reg_addr == 8'h0f || reg_addr == 8'h42)
		|=> reg_rdata == 8'h00) else $error("indirect word visible");
	AST_ENH_RD: assert property (reg_rd && reg_addr == 8'h6c
		|=> reg_rdata[5:0] == {sel[3], 2'b00, sel[2:0]}) else $error("enhance readback");
	AST_ENH_WR: assert property (s_enh_wr
		|=> sel == {$past(reg_wdata[5]), $past(reg_wdata[2:0])}) else $error("select write");
	AST_ENH_HOLD: assert property (!(reg_wr && reg_addr == 8'h6c) |=> $stable(sel))
		else $error("select moved");
	AST_REQ: assert property (s_req |=> pend) else $error("no pending");
	AST_SVC: assert property ($rose(pend) |-> ##[1:SLOT_MAX] !pend)
		else $error("not serviced in slot");
	AST_IDLE: assert property (!pend && !(reg_wr && reg_addr == 8'h1e) |=> !pend)
		else $error("spurious pending");
	AST_PEND_RD: assert property (reg_rd && reg_addr == 8'h1f
		|=> reg_rdata[0] == $past(pend)) else $error("pending readback");
endmodule
bind ira_top ira_sva #(.SLOT_CYCLES(SLOT_CYCLES)) u_sva (.core_clk, .nrst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .converter_speedup_sel,
	.voltage_loop_closure_sel, .converter_audio_squelch_en, .loop_closure_hyst_en,
	.indirect_access_pending);

// File: bench/ira_host.sv
// Host software model on the direct register port
`timescale 1ns/100ps
module ira_host (
	input wire core_clk,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata,
	output reg reg_wr,
	output reg reg_rd,
	input wire [7:0] reg_rdata
);
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
	end
	task wr(input [7:0] a, input [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Stale values never linger on an idle bus
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
	task wait_idle(output [7:0] v);
		v = 8'h01;
		while (v[0]) rd(8'h1f, v);
	endtask
endmodule

// File: bench/ira_top_test.sv
// Self-checking bench for the indirect access engine
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("Error %0t: got %h want %h", $time, a, e); end end
module ira_top_test;
	reg core_clk = 1'b0;
	reg nrst = 1'b0;
	reg [15:0] cur = 16'h0;
	reg [15:0] volt = 16'h0;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, spd, vlc, sq, hy, closed, pend, irq;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	reg [7:0] v, b, lo, hi;
	always #2 core_clk = ~core_clk;
	ira_host h (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	ira_top #(.SLOT_CYCLES(32)) i_ira_top (.core_clk, .nrst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .loop_current_meas(cur), .loop_voltage_meas(volt),
		.converter_speedup_sel(spd), .voltage_loop_closure_sel(vlc),
		.converter_audio_squelch_en(sq), .loop_closure_hyst_en(hy), .loop_closed(closed),
		.indirect_access_pending(pend), .indirect_done_irq(irq));
	task print_verdict;
		if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			print_verdict;
		end
	end
	task ind_wr(input [7:0] a, input [15:0] d);
		h.wr(8'h1c, d[7:0]);
		h.wr(8'h1d, d[15:8]);
		h.wr(8'h1e, a);
		#1 `CHK(pend, 1'b1)
		h.wait_idle(v);
	endtask
	task lc(input [15:0] c, input [15:0] vv, input e);
		@(posedge core_clk);
		cur <= c;
		volt <= vv;
		repeat (3) @(posedge core_clk);
		#1 `CHK(closed, e)
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			b = 8'h01 << i;
			h.wr(8'h6c, b);
			h.rd(8'h6c, v);
			`CHK(v, b & 8'he7)
			`CHK({spd, vlc, sq, hy}, {b[5], b[2:0]})
		end
		h.rd(8'h42, v);
		`CHK(v, 8'h00)
		h.wr(8'h17, 8'h01);
		ind_wr(8'h0f, 16'h0100);
		ind_wr(8'h42, 16'h0080);
		h.rd(8'h14, v);
		`CHK({v[0], irq}, 2'b11)
		h.wr(8'h14, 8'h01);
		#1 `CHK(irq, 1'b0)
		h.wr(8'h1e, 8'h0f);
		h.wait_idle(v);
		h.rd(8'h1c, lo);
		h.rd(8'h1d, hi);
		`CHK({hi, lo}, 16'h0100)
		h.wr(8'h6c, 8'h01);
		lc(16'h0120, 16'h0, 1'b1);
		lc(16'h00a0, 16'h0, 1'b1);
		lc(16'h0070, 16'h0, 1'b0);
		lc(16'h00a0, 16'h0, 1'b0);
		lc(16'h0120, 16'h0, 1'b1);
		h.wr(8'h6c, 8'h00);
		lc(16'h00a0, 16'h0, 1'b0);
		h.wr(8'h6c, 8'h04);
		lc(16'h0000, 16'h0120, 1'b1);
		print_verdict;
	end
endmodule
